// ===== hdl/lid_params.svh
// constants for the line interface pin drive register
// assumes inclusion by bare name from design files under hdl/
`ifndef LID_PARAMS_SVH
`define LID_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define LID_ADDR_W          8
`define LID_DATA_W          8
`define LID_DRIVE_ADDR      8'h72

// ----------------------------------------------------------------
// field positions and reset value
// ----------------------------------------------------------------
`define LID_BIT_RSVD_HI     7
`define LID_BIT_RSVD_LO     6
`define LID_BIT_EQ          5
`define LID_BIT_ALL_ONES    4
`define LID_BIT_CODEC_DIS   3
`define LID_BIT_BUILDOUT    2
`define LID_DRIVE_RESET     8'h08
`define LID_UNMAPPED_READ   8'h00

`endif

// ===== hdl/lid_pkg.sv
// types shared by the line interface pin drive design
// assumes lid_params.svh supplies the data width
`default_nettype none
`include "lid_params.svh"

package lid_pkg;

    // ------------------------------------------------------------
    // register port state of the top module
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`LID_DATA_W-1:0] rdata;
        logic                   rd_valid;
    } lid_port_state_t;

endpackage

`default_nettype wire

// ===== hdl/lid_field_if.sv
// carrier between the top module and its storage field
// assumes one owner drives value and one user drives the write side
`timescale 1ns/1ps
`default_nettype none

interface lid_field_if #(
    parameter int W = 8
);
    logic         wr_en;
    logic [W-1:0] wr_data;
    logic [W-1:0] value;

    modport owner (
        input  wr_en,
        input  wr_data,
        output value
    );
    modport user (
        output wr_en,
        output wr_data,
        input  value
    );
endinterface

`default_nettype wire

// ===== hdl/lid_field.sv
// one software-writable storage field with a reset value
// assumes a single clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module lid_field #(
    parameter int           W     = 8,
    parameter logic [W-1:0] RESET = '0
) (
    // clock and reset
    input  wire logic   core_clk_in,
    input  wire logic   rst_in,
    // field access
    lid_field_if.owner  fld
);
    typedef struct packed {
        logic [W-1:0] value;
    } lid_fld_state_t;

    lid_fld_state_t state;
    lid_fld_state_t next_state;

    always_comb begin
        next_state = state;
        if (fld.wr_en) begin
            next_state.value = fld.wr_data;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state.value <= RESET;
        end else begin
            state <= next_state;
        end
    end

    assign fld.value = state.value;
endmodule

`default_nettype wire

// ===== hdl/lid_drive.sv
// line interface pin drive register and its static strap pins
// What this block does
// - bit 5 sets equalizer pin level; 0 drives low, enabling equalizer.
// - bit 5 at 1 drives equalizer pin high until rewritten.
// - bit 4 sets all-ones pin; 0 low requests all-ones, 1 high.
// - bit 3 sets codec disable pin; resets to 1, pin high.
// - bit 2 sets build-out pin; 0 low enables, 1 high disables.
// - pin bits read back last write; eq, all-ones, build-out reset 0.
//
// assumes a byte-wide processor port synchronous to core_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "lid_params.svh"

module lid_drive #(
    parameter logic [`LID_ADDR_W-1:0] DRIVE_ADDR = `LID_DRIVE_ADDR
) (
    // clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    // processor register port
    input  wire logic [`LID_ADDR_W-1:0] cpu_addr_in,
    input  wire logic                   cpu_wr_in,
    input  wire logic                   cpu_rd_in,
    input  wire logic [`LID_DATA_W-1:0] cpu_wdata_in,
    output logic      [`LID_DATA_W-1:0] cpu_rdata_out,
    output logic                        cpu_rd_valid_out,
    // strap pins toward the line interface unit
    output logic                        rx_equalizer_ctl_out,
    output logic                        tx_all_ones_ctl_out,
    output logic                        line_codec_disable_out,
    output logic                        tx_buildout_ctl_out
);
    // ------------------------------------------------------------
    // address decode and storage
    // ------------------------------------------------------------
    logic wr_hit;
    logic rd_hit;

    assign wr_hit = cpu_wr_in && (cpu_addr_in == DRIVE_ADDR);
    assign rd_hit = cpu_rd_in && (cpu_addr_in == DRIVE_ADDR);

    lid_field_if #(.W(`LID_DATA_W)) drive_if ();

    // whole byte stored so reserved and loopback bits read back
    assign drive_if.wr_en   = wr_hit;
    assign drive_if.wr_data = cpu_wdata_in;

    lid_field #(
        .W     (`LID_DATA_W),
        .RESET (`LID_DRIVE_RESET)
    ) u_drive (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .fld         (drive_if.owner)
    );

    // ------------------------------------------------------------
    // strap pins
    // ------------------------------------------------------------
    // pins are taps of the storage flops: no glitch path from the bus
    assign rx_equalizer_ctl_out   = drive_if.value[`LID_BIT_EQ];
    assign tx_all_ones_ctl_out    = drive_if.value[`LID_BIT_ALL_ONES];
    assign line_codec_disable_out = drive_if.value[`LID_BIT_CODEC_DIS];
    assign tx_buildout_ctl_out    = drive_if.value[`LID_BIT_BUILDOUT];

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    lid_pkg::lid_port_state_t state;
    lid_pkg::lid_port_state_t next_state;

    always_comb begin
        next_state          = state;
        next_state.rd_valid = cpu_rd_in;
        if (rd_hit) begin
            next_state.rdata = drive_if.value;
        end else if (cpu_rd_in) begin
            next_state.rdata = `LID_UNMAPPED_READ;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state.rdata    <= `LID_UNMAPPED_READ;
            state.rd_valid <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign cpu_rdata_out    = state.rdata;
    assign cpu_rd_valid_out = state.rd_valid;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    property p_eq_follows_write;
        wr_hit |=> rx_equalizer_ctl_out == $past(cpu_wdata_in[5]);
    endproperty
    a_eq_follows_write : assert property (p_eq_follows_write)
        else $error("equalizer pin does not follow written bit");

    property p_pins_hold;
        !wr_hit |=> $stable({rx_equalizer_ctl_out, tx_all_ones_ctl_out,
                             line_codec_disable_out, tx_buildout_ctl_out});
    endproperty
    a_pins_hold : assert property (p_pins_hold)
        else $error("strap pin moved without a write");

    property p_all_ones_follows;
        wr_hit |=> tx_all_ones_ctl_out == $past(cpu_wdata_in[4]);
    endproperty
    a_all_ones_follows : assert property (p_all_ones_follows)
        else $error("all-ones pin does not follow written bit");

    property p_codec_follows_write;
        wr_hit ##1 !wr_hit [*2] |-> line_codec_disable_out
            == $past(cpu_wdata_in[3], 2);
    endproperty
    a_codec_follows_write : assert property (p_codec_follows_write)
        else $error("codec disable pin lost its written level");

    property p_buildout_follows;
        wr_hit |=> tx_buildout_ctl_out == $past(cpu_wdata_in[2]);
    endproperty
    a_buildout_follows : assert property (p_buildout_follows)
        else $error("build-out pin does not follow written bit");

    // a high equalizer strap must not decay while software is idle
    property p_eq_high_holds;
        rx_equalizer_ctl_out && !wr_hit |=> rx_equalizer_ctl_out;
    endproperty
    a_eq_high_holds : assert property (p_eq_high_holds)
        else $error("equalizer pin left its high level without a write");

    // bits 1:0 have no pins here but must still be kept
    property p_low_bits_stored;
        wr_hit |=> drive_if.value[1:0] == $past(cpu_wdata_in[1:0]);
    endproperty
    a_low_bits_stored : assert property (p_low_bits_stored)
        else $error("low register bits not stored");

    property p_other_write_ignored;
        cpu_wr_in && !wr_hit |=> $stable(drive_if.value);
    endproperty
    a_other_write_ignored : assert property (p_other_write_ignored)
        else $error("write to another address changed the register");

    property p_reset_levels;
        $fell(rst_in) |-> !rx_equalizer_ctl_out && !tx_all_ones_ctl_out
            && line_codec_disable_out && !tx_buildout_ctl_out;
    endproperty
    a_reset_levels : assert property (@(posedge core_clk_in)
        p_reset_levels)
        else $error("strap pins wrong after reset");

    // ------------------------------------------------------------
    // checks on the register port
    // ------------------------------------------------------------
    property p_reset_port;
        $fell(rst_in) |-> !cpu_rd_valid_out
            && cpu_rdata_out == `LID_UNMAPPED_READ;
    endproperty
    a_reset_port : assert property (p_reset_port)
        else $error("read port not idle after reset");

    property p_readback;
        wr_hit ##1 (rd_hit && !wr_hit) |=> cpu_rd_valid_out
            && cpu_rdata_out == $past(cpu_wdata_in, 2);
    endproperty
    a_readback : assert property (p_readback)
        else $error("read does not return last written value");

    property p_reserved_readback;
        rd_hit |=> cpu_rdata_out[7:6] == $past(drive_if.value[7:6])
            && cpu_rdata_out[5:2] == $past({rx_equalizer_ctl_out,
               tx_all_ones_ctl_out, line_codec_disable_out,
               tx_buildout_ctl_out});
    endproperty
    a_reserved_readback : assert property (p_reserved_readback)
        else $error("reserved bits or pin bits read wrong");

    property p_unmapped_read;
        (cpu_rd_in && !rd_hit) |=> cpu_rd_valid_out
            && cpu_rdata_out == `LID_UNMAPPED_READ;
    endproperty
    a_unmapped_read : assert property (p_unmapped_read)
        else $error("unmapped read did not return zero");

    // a read in the cycle of a write sees the byte before that write
    property p_same_cycle_old;
        wr_hit && rd_hit |=> cpu_rdata_out == $past(drive_if.value);
    endproperty
    a_same_cycle_old : assert property (p_same_cycle_old)
        else $error("read in the write cycle did not return old value");

    property p_rd_valid_pulse;
        cpu_rd_valid_out |-> $past(cpu_rd_in);
    endproperty
    a_rd_valid_pulse : assert property (p_rd_valid_pulse)
        else $error("read answer marked without a read");

    property p_rdata_holds;
        !cpu_rd_in |=> $stable(cpu_rdata_out);
    endproperty
    a_rdata_holds : assert property (p_rdata_holds)
        else $error("read data changed without a read");

    // ------------------------------------------------------------
    // scenarios to be reached
    // ------------------------------------------------------------
    c_write_eq_high : cover property (wr_hit && cpu_wdata_in[5]);
    c_write_then_read : cover property (wr_hit ##1 rd_hit);
    c_unmapped_read : cover property (cpu_rd_in && !rd_hit);
    c_same_cycle : cover property (wr_hit && rd_hit);
    c_codec_enabled : cover property (wr_hit && !cpu_wdata_in[3]);
endmodule

`default_nettype wire

// ===== sim/lid_liu_model.sv
// model of the line interface unit strap inputs
// assumes the four strap pins come straight from lid_drive
`timescale 1ns/1ps
`default_nettype none

module lid_liu_model (
    // strap pins from the framer
    input  wire logic  eq_pin_in,
    input  wire logic  all_ones_pin_in,
    input  wire logic  codec_pin_in,
    input  wire logic  buildout_pin_in,
    // features turned on: eq, all-ones, codec, build-out
    output logic [3:0] feature_on_out
);
    // every strap is active low at the unit
    assign feature_on_out = ~{eq_pin_in, all_ones_pin_in, codec_pin_in,
                              buildout_pin_in};
endmodule

`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the line interface pin drive register
// assumes lid_drive and lid_liu_model are compiled beforehand
`timescale 1ns/1ps
`default_nettype none
`include "lid_params.svh"

module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       core_clk_in, rst_in, wr, rd, rdv, eq, ao, cd, bo;
    logic [7:0] addr, wdata, rdata, shadow;
    logic [3:0] feat;
    int         fail_count, n_tests, cycles;

    lid_drive i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .cpu_addr_in(addr), .cpu_wr_in(wr), .cpu_rd_in(rd),
        .cpu_wdata_in(wdata), .cpu_rdata_out(rdata),
        .cpu_rd_valid_out(rdv), .rx_equalizer_ctl_out(eq),
        .tx_all_ones_ctl_out(ao), .line_codec_disable_out(cd),
        .tx_buildout_ctl_out(bo));
    lid_liu_model i_liu (.eq_pin_in(eq), .all_ones_pin_in(ao),
        .codec_pin_in(cd), .buildout_pin_in(bo), .feature_on_out(feat));

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_read(input logic [7:0] a);
        return (a == `LID_DRIVE_ADDR) ? shadow : `LID_UNMAPPED_READ;
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_byte(input string what, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // pin levels and what the unit makes of them
    task automatic chk_pins(input logic [7:0] e);
        n_tests++;
        if ({eq, ao, cd, bo} !== e[5:2] || feat !== ~e[5:2]) begin
            fail_count++;
            $display("MISMATCH pins expected %h seen %h", e[5:2],
                     {eq, ao, cd, bo});
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge core_clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
        if (a == `LID_DRIVE_ADDR) shadow = d;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge core_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
        chk_byte("rd_valid", 8'h01, {7'h00, rdv});
        chk_byte("rdata", exp_read(a), rdata);
        @(posedge core_clk_in);
        #1;
        chk_byte("rd_valid_end", 8'h00, {7'h00, rdv});
    endtask

    // write then read in the next cycle, or both in one cycle
    task automatic wr_rd_reg(input logic [7:0] d, input bit same);
        logic [7:0] old;
        old = shadow;
        @(posedge core_clk_in);
        addr  <= `LID_DRIVE_ADDR;
        wdata <= d;
        wr    <= 1'b1;
        rd    <= same;
        @(posedge core_clk_in);
        wr <= 1'b0;
        rd <= !same;
        shadow = d;
        if (!same) begin
            @(posedge core_clk_in);
            rd <= 1'b0;
        end
        #1;
        chk_byte("rd_valid_wr_rd", 8'h01, {7'h00, rdv});
        chk_byte("rdata_wr_rd", same ? old : d, rdata);
        chk_pins(shadow);
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge core_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {fail_count, n_tests, cycles} = '0;
        {addr, wdata, wr, rd} = '0;
        shadow = `LID_DRIVE_RESET;
        rst_in = 1'b1;
        void'($urandom(32'h28b17984));
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        #1;
        chk_pins(shadow);
        rd_reg(`LID_DRIVE_ADDR);
        $display("test reset done");
        for (int b = 2; b < 6; b++) begin
            wr_reg(`LID_DRIVE_ADDR, 8'h01 << b);
            chk_pins(shadow);
            // a neighbour write must leave the straps alone
            wr_reg(8'h71, 8'hff);
            chk_pins(shadow);
            rd_reg(8'h71);
        end
        $display("test walk done");
        repeat (40) begin
            // reserved bits kept 0 by software
            wr_reg(`LID_DRIVE_ADDR, 8'($urandom) & 8'h3f);
            chk_pins(shadow);
            rd_reg(`LID_DRIVE_ADDR);
        end
        $display("test random done");
        wr_reg(`LID_DRIVE_ADDR, 8'hc3);
        chk_pins(shadow);
        rd_reg(`LID_DRIVE_ADDR);
        $display("test reserved done");
        repeat (8) begin
            wr_rd_reg(8'($urandom) & 8'h3f, 1'b0);
            wr_rd_reg(8'($urandom) & 8'h3f, 1'b1);
        end
        $display("test back to back done");
        // reset in mid-run must bring back the strap defaults at once
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        shadow = `LID_DRIVE_RESET;
        #1;
        chk_pins(shadow);
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        #1;
        chk_pins(shadow);
        rd_reg(`LID_DRIVE_ADDR);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule

`default_nettype wire
